// *** brca_bcd_step.sv ***
`timescale 1ns/1ps
// ============================================================
// one bcd calendar field: increment with wrap
// ============================================================
module brca_bcd_step (
  input wire logic [7:0] i_val,
  input wire logic [7:0] i_min,
  input wire logic [7:0] i_max,
  input wire logic i_inc,
  output logic [7:0] o_next,
  output logic o_wrap
);

  // ==========================================================
  // increment
  // ==========================================================
  // at or past the top the field wraps, so a bad value recovers
  always_comb begin
    o_next = i_val;
    o_wrap = 1'b0;
    if (i_inc) begin
      if (i_val >= i_max) begin
        o_next = i_min;
        o_wrap = 1'b1;
      end else if (i_val[3:0] >= 4'h9) begin
        o_next = {i_val[7:4] + 4'h1, 4'h0};
      end else begin
        o_next = {i_val[7:4], i_val[3:0] + 4'h1};
      end
    end
  end

endmodule

// *** brca_pkg.sv ***
// ============================================================
// shared constants and types of the clock/calendar block
// ============================================================
package brca_pkg;

  // ==========================================================
  // register byte offsets on the apb bus
  // ==========================================================
  localparam logic [7:0] BRCA_OFS_CAL = 8'h00;
  localparam logic [7:0] BRCA_OFS_PAD = 8'h04;
  localparam logic [7:0] BRCA_OFS_ALM = 8'h08;
  localparam logic [7:0] BRCA_OFS_TIME = 8'h0C;
  localparam logic [7:0] BRCA_OFS_AWIN = 8'h10;

  // ==========================================================
  // field positions
  // ==========================================================
  localparam int BRCA_CAL_ON_BIT = 15;
  localparam int BRCA_CAL_UNLOCK_BIT = 13;
  localparam int BRCA_CAL_SYNC_BIT = 12;
  localparam int BRCA_CAL_HALF_BIT = 11;
  localparam int BRCA_CAL_PINEN_BIT = 10;
  localparam int BRCA_CAL_PTR_LSB = 8;
  localparam int BRCA_PAD_SEL_LSB = 1;
  localparam int BRCA_ALM_ON_BIT = 15;
  localparam int BRCA_ALM_CHIME_BIT = 14;
  localparam int BRCA_ALM_MASK_LSB = 10;
  localparam int BRCA_ALM_PTR_LSB = 8;

  // ==========================================================
  // bcd field masks and limits
  // ==========================================================
  localparam logic [7:0] BRCA_MSK_SEC = 8'h7F;
  localparam logic [7:0] BRCA_MSK_HR = 8'h3F;
  localparam logic [7:0] BRCA_MSK_WD = 8'h07;
  localparam logic [7:0] BRCA_MSK_MTH = 8'h1F;
  localparam logic [7:0] BRCA_MAX_SEC = 8'h59;
  localparam logic [7:0] BRCA_MAX_HR = 8'h23;
  localparam logic [7:0] BRCA_MAX_WD = 8'h06;
  localparam logic [7:0] BRCA_MAX_MTH = 8'h12;
  localparam logic [7:0] BRCA_MAX_YR = 8'h99;
  localparam logic [7:0] BRCA_ONE = 8'h01;
  localparam logic [7:0] BRCA_REPEAT_TOP = 8'hFF;

  // ==========================================================
  // reset values and timing counts
  // ==========================================================
  localparam logic [7:0] BRCA_RST_YEAR = 8'h00;
  localparam logic [7:0] BRCA_RST_MONTH = 8'h01;
  localparam logic [7:0] BRCA_RST_DAY = 8'h01;
  localparam int BRCA_REF_PER_SEC = 32768;
  localparam int BRCA_SYNC_WIN = 32;

  // source routed to the clock output pin
  typedef enum logic [1:0] {
    BRCA_PIN_ALARM,
    BRCA_PIN_SECONDS,
    BRCA_PIN_REFCLK,
    BRCA_PIN_RSVD
  } brca_pin_src_t;

  // state of the input synchroniser
  typedef struct packed {
    logic [2:0] ff;
    logic level;
    logic rise;
  } brca_sync_state_t;

  // whole state of the top module
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic on;
    logic unlock;
    logic pin_en;
    logic [1:0] tptr;
    logic [7:0] cal;
    brca_pin_src_t pin_sel;
    logic alm_on;
    logic chime;
    logic [3:0] amask;
    logic [1:0] aptr;
    logic [7:0] arpt;
    logic [7:0] sec;
    logic [7:0] min;
    logic [7:0] hr;
    logic [7:0] wd;
    logic [7:0] day;
    logic [7:0] mth;
    logic [7:0] yr;
    logic [7:0] asec;
    logic [7:0] amin;
    logic [7:0] ahr;
    logic [7:0] awd;
    logic [7:0] aday;
    logic [7:0] amth;
    logic signed [16:0] pre;
    logic half_ev;
    logic sec_ev;
    logic alm_pulse;
    logic pin;
    logic pin_oe;
  } brca_top_state_t;

  localparam brca_top_state_t BRCA_TOP_RST = '{
    pin_sel: BRCA_PIN_ALARM,
    yr: BRCA_RST_YEAR,
    mth: BRCA_RST_MONTH,
    day: BRCA_RST_DAY,
    default: '0
  };

endpackage

// *** brca_sync.sv ***
`timescale 1ns/1ps
// ============================================================
// three-stage synchroniser with agreement filter
// ============================================================
module brca_sync import brca_pkg::*; (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_async,
  output logic o_level,
  output logic o_rise
);

  brca_sync_state_t s_q; // registered state
  brca_sync_state_t s_d; // next state

  // ==========================================================
  // next state
  // ==========================================================
  // first stage feeds only the second; level moves once 2 and 3 agree
  always_comb begin
    s_d = s_q;
    s_d.ff = {s_q.ff[1:0], i_async};
    if (s_q.ff[1] == s_q.ff[2]) begin
      s_d.level = s_q.ff[2];
    end
    s_d.rise = s_d.level & ~s_q.level;
  end

  // ==========================================================
  // registers
  // ==========================================================
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_level = s_q.level;
  assign o_rise = s_q.rise;

endmodule

// *** brca_top.sv ***
`timescale 1ns/1ps
module brca_top import brca_pkg::*; #(
  parameter int REF_DIV = BRCA_REF_PER_SEC,
  parameter int ADDR_W = 8
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_crystal_osc,
  input wire logic i_lowpower_internal_osc,
  input wire logic i_reference_clock_sel,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_clock_pin,
  output logic o_clock_pin_oe
);

  // ==========================================================
  // elaboration checks
  // ==========================================================
  // prescaler must hold -512..REF_DIV-1 in 17 signed bits
  if (REF_DIV < 1024 || REF_DIV > 65536 || (REF_DIV % 2) != 0) begin : g_bad_div
    $error("REF_DIV out of range");
  end
  if (ADDR_W < 5) begin : g_bad_addr
    $error("ADDR_W too small");
  end

  localparam logic signed [16:0] PRE_TOP = 17'(REF_DIV - 1); // last tick of a second
  localparam logic signed [16:0] PRE_HALF = 17'(REF_DIV / 2); // start of second half
  localparam logic signed [16:0] PRE_SYNC = 17'(REF_DIV - BRCA_SYNC_WIN); // ripple window

  brca_top_state_t s_q; // registered state
  brca_top_state_t s_d; // next state
  logic ref_level; // filtered reference clock
  logic ref_rise; // one pulse per reference edge
  logic ref_tick; // counted reference edge
  logic sec_tick; // second boundary
  logic half_tick; // half second boundary
  logic half_flag; // in second half of second
  logic sync_flag; // rollover imminent
  logic [7:0] cur [7]; // field values, sec..yr, weekday
  logic [7:0] lo [7]; // field minimums
  logic [7:0] hi [7]; // field maximums
  logic [7:0] nxt [7]; // field next values
  logic inc [7]; // field increment
  logic wrap [7]; // field carry out
  logic alm_hit; // alarm match this half second
  logic [31:0] rd; // read data mux
  logic hit; // address is mapped
  logic [7:0] ofs; // byte offset
  logic [15:0] wd16; // write data low half
  logic access; // access phase completes now
  logic [15:0] twin; // time window read
  logic [15:0] awin; // alarm window read

  // ==========================================================
  // functions
  // ==========================================================
  // window pair decode, shared by time and alarm windows
  function automatic logic [15:0] brca_win_pick(input logic [1:0] ptr, input logic [15:0] w0,
      input logic [15:0] w1, input logic [15:0] w2, input logic [15:0] w3);
    logic [15:0] r;
    r = w0;
    unique case (ptr)
      2'b00: r = w0;
      2'b01: r = w1;
      2'b10: r = w2;
      2'b11: r = w3;
    endcase
    return r;
  endfunction

  // last day of month in bcd
  function automatic logic [7:0] brca_month_len(input logic [7:0] mth, input logic [7:0] yr);
    logic leap;
    leap = (!yr[4] && (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8)) ||
        (yr[4] && (yr[3:0] == 4'h2 || yr[3:0] == 4'h6));
    case (mth)
      8'h02: brca_month_len = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: brca_month_len = 8'h30;
      default: brca_month_len = 8'h31;
    endcase
  endfunction

  // ==========================================================
  // reference clock capture
  // ==========================================================
  // source mux ahead of the synchroniser; the strap is static
  brca_sync u_ref_sync (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_async(i_reference_clock_sel ? i_crystal_osc : i_lowpower_internal_osc),
    .o_level(ref_level),
    .o_rise(ref_rise)
  );

  // prescaler events; the clock only runs while the module is on
  assign ref_tick = s_q.on & ref_rise;
  assign sec_tick = ref_tick & (s_q.pre == PRE_TOP);
  assign half_tick = ref_tick & (s_q.pre == PRE_HALF - 17'sd1);
  assign half_flag = s_q.pre >= PRE_HALF;
  assign sync_flag = s_q.on & (s_q.pre >= PRE_SYNC);

  // ==========================================================
  // calendar fields
  // ==========================================================
  assign cur = '{s_q.sec, s_q.min, s_q.hr, s_q.day, s_q.mth, s_q.yr, s_q.wd};
  assign lo = '{8'h00, 8'h00, 8'h00, BRCA_ONE, BRCA_ONE, 8'h00, 8'h00};
  assign hi = '{BRCA_MAX_SEC, BRCA_MAX_SEC, BRCA_MAX_HR, brca_month_len(s_q.mth, s_q.yr),
      BRCA_MAX_MTH, BRCA_MAX_YR, BRCA_MAX_WD};
  assign inc[0] = sec_tick;
  assign inc[1] = wrap[0];
  assign inc[2] = wrap[1];
  assign inc[3] = wrap[2];
  assign inc[4] = wrap[3];
  assign inc[5] = wrap[4];
  assign inc[6] = wrap[2];

  for (genvar g = 0; g < 7; g++) begin : g_field
    brca_bcd_step u_step (
      .i_val(cur[g]),
      .i_min(lo[g]),
      .i_max(hi[g]),
      .i_inc(inc[g]),
      .o_next(nxt[g]),
      .o_wrap(wrap[g])
    );
  end

  // ==========================================================
  // alarm match
  // ==========================================================
  // checked one cycle after the boundary, against updated time;
  // a february 29 date only matches in a leap year
  always_comb begin
    alm_hit = 1'b0;
    case (s_q.amask)
      4'h0: alm_hit = 1'b1;
      4'h1: alm_hit = s_q.sec_ev;
      4'h2: alm_hit = s_q.sec_ev && s_q.sec[3:0] == s_q.asec[3:0];
      4'h3: alm_hit = s_q.sec_ev && s_q.sec == s_q.asec;
      4'h4: alm_hit = s_q.sec_ev && s_q.sec == s_q.asec && s_q.min[3:0] == s_q.amin[3:0];
      4'h5: alm_hit = s_q.sec_ev && {s_q.sec, s_q.min} == {s_q.asec, s_q.amin};
      4'h6: alm_hit = s_q.sec_ev && {s_q.sec, s_q.min, s_q.hr} == {s_q.asec, s_q.amin, s_q.ahr};
      4'h7: alm_hit = s_q.sec_ev && {s_q.sec, s_q.min, s_q.hr, s_q.wd} ==
          {s_q.asec, s_q.amin, s_q.ahr, s_q.awd};
      4'h8: alm_hit = s_q.sec_ev && {s_q.sec, s_q.min, s_q.hr, s_q.day} ==
          {s_q.asec, s_q.amin, s_q.ahr, s_q.aday};
      4'h9: alm_hit = s_q.sec_ev && {s_q.sec, s_q.min, s_q.hr, s_q.day, s_q.mth} ==
          {s_q.asec, s_q.amin, s_q.ahr, s_q.aday, s_q.amth};
      default: alm_hit = 1'b0;
    endcase
    alm_hit = alm_hit & s_q.alm_on & s_q.half_ev;
  end

  // ==========================================================
  // register read decode
  // ==========================================================
  // time and alarm window pairs
  // year in low byte, upper byte zero
  assign twin = brca_win_pick(s_q.tptr, {s_q.min, s_q.sec}, {s_q.wd, s_q.hr},
      {s_q.mth, s_q.day}, {8'h00, s_q.yr});
  assign awin = brca_win_pick(s_q.aptr, {s_q.amin, s_q.asec}, {s_q.awd, s_q.ahr},
      {s_q.amth, s_q.aday}, 16'h0000);
  assign ofs = 8'(i_paddr);
  assign wd16 = i_pwdata[15:0];
  assign access = i_psel & i_penable & s_q.pready;

  always_comb begin
    hit = 1'b1;
    rd = 32'h0000_0000;
    case (ofs)
      BRCA_OFS_CAL: rd = {16'h0000, s_q.on, 1'b0, s_q.unlock, sync_flag, half_flag,
          s_q.pin_en, s_q.tptr, s_q.cal};
      BRCA_OFS_PAD: rd = {29'h0, s_q.pin_sel, 1'b0};
      BRCA_OFS_ALM: rd = {16'h0000, s_q.alm_on, s_q.chime, s_q.amask, s_q.aptr, s_q.arpt};
      BRCA_OFS_TIME: rd = {16'h0000, twin};
      BRCA_OFS_AWIN: rd = {16'h0000, awin};
      // unmapped: error answer, zero data
      default: hit = 1'b0;
    endcase
  end

  // ==========================================================
  // next state
  // ==========================================================
  always_comb begin
    s_d = s_q;
    // ---- prescaler and drift calibration ----
    if (ref_tick) begin
      s_d.pre = s_q.pre + 17'sd1;
    end
    if (sec_tick) begin
      // on a minute wrap, a positive count starts the next second 4*cal ticks in
      // negative count starts it 4*|cal| ticks early, zero none
      s_d.pre = wrap[0] ? $signed({{7{s_q.cal[7]}}, s_q.cal, 2'b00}) : 17'sd0;
      s_d.sec = nxt[0];
      s_d.min = nxt[1];
      s_d.hr = nxt[2];
      s_d.day = nxt[3];
      s_d.mth = nxt[4];
      s_d.yr = nxt[5];
      s_d.wd = nxt[6];
    end
    s_d.sec_ev = sec_tick;
    s_d.half_ev = sec_tick | half_tick;

    // ---- apb slave, zero wait states ----
    s_d.pready = i_psel & ~i_penable;
    if (i_psel & ~i_penable) begin
      s_d.prdata = rd;
      s_d.pslverr = ~hit | (i_paddr[1:0] != 2'b00);
    end
    if (access && hit && i_paddr[1:0] == 2'b00) begin
      if (i_pwrite) begin
        case (ofs)
          BRCA_OFS_CAL: begin
            if (i_pstrb[1]) begin
              if (s_q.unlock) begin
                s_d.on = wd16[BRCA_CAL_ON_BIT];
              end
              s_d.unlock = wd16[BRCA_CAL_UNLOCK_BIT];
              s_d.pin_en = wd16[BRCA_CAL_PINEN_BIT];
              s_d.tptr = wd16[BRCA_CAL_PTR_LSB+:2];
            end
            if (i_pstrb[0]) begin
              s_d.cal = wd16[7:0];
            end
          end
          BRCA_OFS_PAD: begin
            if (i_pstrb[0]) begin
              s_d.pin_sel = brca_pin_src_t'(wd16[BRCA_PAD_SEL_LSB+:2]);
            end
          end
          BRCA_OFS_ALM: begin
            if (i_pstrb[1]) begin
              s_d.alm_on = wd16[BRCA_ALM_ON_BIT];
              s_d.chime = wd16[BRCA_ALM_CHIME_BIT];
              s_d.amask = wd16[BRCA_ALM_MASK_LSB+:4];
              s_d.aptr = wd16[BRCA_ALM_PTR_LSB+:2];
            end
            if (i_pstrb[0]) begin
              s_d.arpt = wd16[7:0];
            end
          end
          BRCA_OFS_TIME: begin
            if (s_q.unlock) begin
              unique case (s_q.tptr)
                2'b00: begin
                  if (i_pstrb[1]) s_d.min = wd16[15:8] & BRCA_MSK_SEC;
                  if (i_pstrb[0]) begin
                    s_d.sec = wd16[7:0] & BRCA_MSK_SEC;
                    // restart the second, half flag clears
                    s_d.pre = 17'sd0;
                  end
                end
                2'b01: begin
                  if (i_pstrb[1]) s_d.wd = wd16[15:8] & BRCA_MSK_WD;
                  if (i_pstrb[0]) s_d.hr = wd16[7:0] & BRCA_MSK_HR;
                end
                2'b10: begin
                  if (i_pstrb[1]) s_d.mth = wd16[15:8] & BRCA_MSK_MTH;
                  if (i_pstrb[0]) s_d.day = wd16[7:0] & BRCA_MSK_HR;
                end
                2'b11: begin
                  if (i_pstrb[0]) s_d.yr = wd16[7:0];
                end
              endcase
            end
            // pointer steps down on high byte write
            if (i_pstrb[1] && s_q.tptr != 2'b00) begin
              s_d.tptr = s_q.tptr - 2'b01;
            end
          end
          BRCA_OFS_AWIN: begin
            unique case (s_q.aptr)
              2'b00: begin
                if (i_pstrb[1]) s_d.amin = wd16[15:8] & BRCA_MSK_SEC;
                if (i_pstrb[0]) s_d.asec = wd16[7:0] & BRCA_MSK_SEC;
              end
              2'b01: begin
                if (i_pstrb[1]) s_d.awd = wd16[15:8] & BRCA_MSK_WD;
                if (i_pstrb[0]) s_d.ahr = wd16[7:0] & BRCA_MSK_HR;
              end
              2'b10: begin
                if (i_pstrb[1]) s_d.amth = wd16[15:8] & BRCA_MSK_MTH;
                if (i_pstrb[0]) s_d.aday = wd16[7:0] & BRCA_MSK_HR;
              end
              2'b11: begin
              end
            endcase
            // pointer steps down on high byte write
            if (i_pstrb[1] && s_q.aptr != 2'b00) begin
              s_d.aptr = s_q.aptr - 2'b01;
            end
          end
          default: begin
          end
        endcase
      end else begin
        // a read covers both bytes, so any window read steps
        // its own pointer down, time or alarm
        if (ofs == BRCA_OFS_TIME && s_q.tptr != 2'b00) begin
          s_d.tptr = s_q.tptr - 2'b01;
        end
        if (ofs == BRCA_OFS_AWIN && s_q.aptr != 2'b00) begin
          s_d.aptr = s_q.aptr - 2'b01;
        end
      end
    end

    // ---- alarm event, after software so hardware wins ----
    if (s_q.half_ev) begin
      s_d.alm_pulse = alm_hit;
    end
    if (alm_hit) begin
      if (s_q.arpt == 8'h00) begin
        if (s_q.chime) begin
          s_d.arpt = BRCA_REPEAT_TOP;
        end else begin
          // last event turns the alarm off
          s_d.alm_on = 1'b0;
        end
      end else begin
        s_d.arpt = s_q.arpt - 8'h01;
      end
    end

    // ---- clock output pin ----
    // source select, reserved code drives low
    unique case (s_q.pin_sel)
      BRCA_PIN_ALARM: s_d.pin = s_q.pin_en & s_q.alm_pulse;
      BRCA_PIN_SECONDS: s_d.pin = s_q.pin_en & ~half_flag;
      BRCA_PIN_REFCLK: s_d.pin = s_q.pin_en & ref_level;
      BRCA_PIN_RSVD: s_d.pin = 1'b0;
    endcase
    s_d.pin_oe = s_q.pin_en;
  end

  // ==========================================================
  // registers
  // ==========================================================
  // the only reset is power-on, so configuration survives others
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_q <= BRCA_TOP_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_prdata = s_q.prdata;
  assign o_pready = s_q.pready;
  assign o_pslverr = s_q.pslverr;
  assign o_clock_pin = s_q.pin;
  assign o_clock_pin_oe = s_q.pin_oe;

endmodule

// *** brca_top_sva.sv ***
`timescale 1ns/1ps
// ==================================================
// apb handshake, register layout and pin enable checks
module brca_top_sva import brca_pkg::*; #(
  parameter int ADDR_W = 8
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_crystal_osc,
  input wire logic i_lowpower_internal_osc,
  input wire logic i_reference_clock_sel,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic o_clock_pin,
  input wire logic o_clock_pin_oe
);
  logic wr_cal; // finished write to the config register
  logic hit; // address names one of the five words
  logic setup; // first cycle of a transfer
  logic rd_end; // last cycle of a read
  assign wr_cal = i_psel && i_penable && o_pready && i_pwrite && i_paddr == BRCA_OFS_CAL;
  assign hit = i_paddr inside {BRCA_OFS_CAL, BRCA_OFS_PAD, BRCA_OFS_ALM, BRCA_OFS_TIME,
    BRCA_OFS_AWIN};
  assign setup = i_psel && !i_penable;
  assign rd_end = o_pready && !i_pwrite;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  a_ready_setup: assert property (setup |=> o_pready) else $error("no ready after setup");
  a_ready_pulse: assert property (o_pready |=> !o_pready) else $error("ready held too long");
  a_ready_idle: assert property (!i_psel |=> !o_pready) else $error("ready without select");
  a_err_unmapped: assert property (setup && !hit |=> o_pslverr) else $error("no error for hole");
  a_ok_mapped: assert property (setup && hit |=> !o_pslverr) else $error("error on register");
  a_err_data: assert property (o_pready && o_pslverr |-> o_prdata == 32'h0)
    else $error("error data");
  a_upper_zero: assert property (rd_end |-> o_prdata[31:16] == 16'h0)
    else $error("upper half");
  a_window_top: assert property (rd_end && i_paddr == BRCA_OFS_TIME |-> !o_prdata[15])
    else $error("time bit 15 set");
  a_pad_gaps: assert property (rd_end && i_paddr == BRCA_OFS_PAD |->
    o_prdata[15:3] == 13'h0 && !o_prdata[0]) else $error("pad gap bits set");
  a_pin_enable: assert property ($changed(o_clock_pin_oe) |->
    $past(wr_cal) || $past(wr_cal, 2)) else $error("pin enable moved alone");
endmodule

bind brca_top brca_top_sva #(.ADDR_W(ADDR_W)) u_sva (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
  .i_crystal_osc(i_crystal_osc), .i_lowpower_internal_osc(i_lowpower_internal_osc),
  .i_reference_clock_sel(i_reference_clock_sel), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_clock_pin(o_clock_pin),
  .o_clock_pin_oe(o_clock_pin_oe));

// *** brca_top_tb.sv ***
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin mismatches++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
// ==================================================
// register level bench, one second = 1024 ref edges
module brca_top_tb import brca_pkg::*; ;
  logic clk = 0, rstn = 0, osc = 0, psel = 0, pen = 0, pwr = 0, pin_d = 0, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rdv, prdata;
  logic pready, pslverr, pin, pin_oe;
  logic [2:0] div = 3'h0;
  logic [3:0] strb = 4'hF; // byte lanes, all on unless a test narrows them
  int mismatches = 0, compares = 0, rises = 0;
  always #2 clk = ~clk;
  // ref clock of ten core cycles, far slower than the synchroniser
  always @(posedge clk) begin
    div <= (div == 3'h4) ? 3'h0 : div + 3'h1;
    if (div == 3'h4) osc <= ~osc;
    pin_d <= pin;
    if (pin && !pin_d) rises++;
  end
  brca_top #(.REF_DIV(1024)) DUT (.i_core_clk(clk), .i_resetn(rstn), .i_crystal_osc(1'b0),
    .i_lowpower_internal_osc(osc), .i_reference_clock_sel(1'b0), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(strb), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .o_clock_pin(pin), .o_clock_pin_oe(pin_oe));
  // ==================================================
  // apb master: hold request until ready is sampled
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // no limit of its own: only the watchdog ends a hung wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    e = pslverr;
    psel <= 1'b0; pen <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
      input string nm);
    apb(1'b0, a, 32'h0);
    `CHK(nm, x, rdv & m)
  endtask
  task print_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog well beyond the ~85k cycles of the tests
  initial begin
    repeat (95000) @(posedge clk);
    mismatches++;
    print_verdict;
  end
  // ==================================================
  // tests
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rd(BRCA_OFS_CAL, 32'hFFFFE7FF, 32'h0, "cal_rst");
    rd(BRCA_OFS_ALM, 32'hFFFFFFFF, 32'h0, "alm_rst");
    apb(1'b0, 8'h14, 32'h0);
    `CHK("hole_err", 1'b1, e)
    $display("reset test done");
    apb(1'b1, BRCA_OFS_CAL, 32'h8200);
    rd(BRCA_OFS_CAL, 32'h8000, 32'h0, "on_locked");
    apb(1'b1, BRCA_OFS_TIME, 32'h0312);
    apb(1'b1, BRCA_OFS_CAL, 32'h0200);
    rd(BRCA_OFS_TIME, 32'hFFFF, 32'h0101, "md_locked");
    rd(BRCA_OFS_TIME, 32'hFFFF, 32'h0000, "wh_ptr1");
    rd(BRCA_OFS_TIME, 32'hFFFF, 32'h0000, "ms_ptr0");
    rd(BRCA_OFS_CAL, 32'h0300, 32'h0, "ptr_floor");
    apb(1'b1, BRCA_OFS_PAD, 32'hFFFF);
    rd(BRCA_OFS_PAD, 32'hFFFF, 32'h0006, "pad_bits");
    $display("lock test done");
    apb(1'b1, BRCA_OFS_CAL, 32'h2300);
    apb(1'b1, BRCA_OFS_TIME, 32'h0024);
    apb(1'b1, BRCA_OFS_TIME, 32'h0228);
    apb(1'b1, BRCA_OFS_TIME, 32'h0623);
    apb(1'b1, BRCA_OFS_TIME, 32'h5959);
    rd(BRCA_OFS_CAL, 32'h0B00, 32'h0, "half_clr");
    apb(1'b1, BRCA_OFS_CAL, 32'hA300);
    repeat (15360) @(posedge clk);
    rd(BRCA_OFS_TIME, 32'hFFFF, 32'h0024, "year");
    rd(BRCA_OFS_TIME, 32'hFFFF, 32'h0229, "leap_day");
    rd(BRCA_OFS_TIME, 32'hFFFF, 32'h0000, "wd_hr");
    rd(BRCA_OFS_TIME, 32'hFFFF, 32'h0000, "min_sec");
    $display("calendar test done");
    apb(1'b1, BRCA_OFS_CAL, 32'hA07F);
    apb(1'b1, BRCA_OFS_TIME, 32'h0059);
    // minute wrap after one second; +508 ticks puts it past the half
    repeat (10840) @(posedge clk);
    rd(BRCA_OFS_CAL, 32'h0800, 32'h0800, "cal_pos");
    apb(1'b1, BRCA_OFS_TIME, 32'h0059);
    rd(BRCA_OFS_CAL, 32'h0800, 32'h0, "half_run");
    apb(1'b1, BRCA_OFS_CAL, 32'hA080);
    // -512 ticks keep the half flag low a half second longer
    repeat (15960) @(posedge clk);
    rd(BRCA_OFS_CAL, 32'h0800, 32'h0, "cal_neg");
    $display("calibration test done");
    apb(1'b1, BRCA_OFS_PAD, 32'h0);
    apb(1'b1, BRCA_OFS_CAL, 32'hA700);
    // enable lands at the write edge, the pin flop one edge later
    repeat (2) @(posedge clk);
    `CHK("oe_on", 1'b1, pin_oe)
    rises = 0;
    apb(1'b1, BRCA_OFS_ALM, 32'h8401);
    repeat (30720) @(posedge clk);
    rd(BRCA_OFS_ALM, 32'hFFFF, 32'h0400, "alm_done");
    `CHK("pulses", 2, rises)
    apb(1'b1, BRCA_OFS_ALM, 32'h0200);
    strb <= 4'h1;
    apb(1'b1, BRCA_OFS_AWIN, 32'h0315);
    strb <= 4'hF;
    apb(1'b1, BRCA_OFS_AWIN, 32'h0315);
    rd(BRCA_OFS_ALM, 32'h0300, 32'h0100, "aptr_step");
    apb(1'b1, BRCA_OFS_ALM, 32'h0300);
    rd(BRCA_OFS_AWIN, 32'hFFFF, 32'h0, "awin_none");
    rd(BRCA_OFS_AWIN, 32'hFFFF, 32'h0315, "awin_md");
    apb(1'b1, BRCA_OFS_ALM, 32'hC400);
    repeat (12288) @(posedge clk);
    apb(1'b0, BRCA_OFS_ALM, 32'h0);
    `CHK("chime_cfg", 8'hC4, rdv[15:8])
    `CHK("chime_cnt", 1'b1, rdv[7:0] >= 8'hFE)
    apb(1'b1, BRCA_OFS_CAL, 32'h2000);
    repeat (2) @(posedge clk);
    `CHK("oe_off", 1'b0, pin_oe)
    $display("alarm test done");
    print_verdict;
  end
endmodule
